// ---- hdl/xcvr_reconfig_map.vh ----
// constants for the transceiver reconfiguration channel addressing front end
// Functional notes
// [RQ1] a channel is chosen only by its logical channel address
// [RQ2] single regular instance: first channel address 0, then step of one
// [RQ3] later instances start at next multiple of four; channels step by one
// [RQ4] every initialization image word is handled as 16 bits
// [RQ5] image words are written only in the channel and transmit-PLL mode group
// [RQ6] that group holds PLL reconfig, channel plus PLL, channel with PLL select
// [RQ7] main and alternate transmit PLL are told apart by a one-bit index
// [RQ8] in channel-with-PLL-select mode transmit PLLs also get logical addresses; here only the PLL of a PMA-only instance does, at offset 6'h10
// [RQ9] one controller per transceiver block; may serve several on-die blocks
// [RQ10] offset cancellation uses reconfig clock, fixed clock for PIPE instances
// [RQ11] offset-cancellation clock is free running, not from any PLL
// [RQ12] reconfig clock is wired to every reconfigurable transceiver instance
// [RQ13] PMA-direct instance: every channel is PMA-only, no PCS path
// [RQ14] PMA-only channel addresses step by four within an instance
// [RQ15] control bus to transceivers is three bits, shared by all instances
// [RQ16] addresses past the total channel count are ignored, nothing changes
// [RQ17] all logic on reconfig clock; idle with no channel selected after reset
`ifndef XCVR_RECONFIG_MAP_VH
`define XCVR_RECONFIG_MAP_VH

// ------------------------------------------------------------
// sizes
// ------------------------------------------------------------
`define RC_ADDR_W 6
`define RC_NUM_INST 2
`define RC_INST_W 1
`define RC_CHAN_W 2
`define RC_WORD_W 16
`define RC_CTRL_W 3
`define RC_MODE_W 3
`define RC_CNT_W 5

// ------------------------------------------------------------
// address layout
// ------------------------------------------------------------
`define RC_ADDR_ZERO 6'h00
`define RC_REG_SPAN 6'h04
`define RC_PMA_SPAN 6'h14
`define RC_PMA_PLL_OFF 6'h10
`define RC_PMA_SHIFT 2
`define RC_PMA_ALIGN_MASK 6'h03

// ------------------------------------------------------------
// modes
// ------------------------------------------------------------
`define RC_MODE_PMA_CTRL 3'h0
`define RC_MODE_PLL_RECONF 3'h1
`define RC_MODE_CH_AND_PLL 3'h2
`define RC_MODE_CH_PLL_SEL 3'h3
`define RC_MODE_OFFSET_CANCEL 3'h4
`define RC_MODE_ADAPT_EQ 3'h5

// ------------------------------------------------------------
// serial frame: address, pll index, image word
// ------------------------------------------------------------
`define RC_FRAME_W 23
`define RC_FRAME_LAST 5'h16
`define RC_CNT_ZERO 5'h00
`define RC_CNT_ONE 5'h01

`endif

// ---- hdl/xcvr_reconfig_channel_addressing.v ----
// channel addressing and image loading front end of the transceiver reconfiguration controller
`timescale 1ns/1ns
`include "xcvr_reconfig_map.vh"

module xcvr_reconfig_channel_addressing (
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire req_valid_i,
	input wire [`RC_MODE_W-1:0] req_mode_i,
	input wire [`RC_ADDR_W-1:0] req_addr_i,
	input wire req_pll_index_i,
	output wire req_ready_o,
	input wire image_valid_i,
	input wire [`RC_WORD_W-1:0] image_word_i,
	input wire image_last_i,
	output wire image_ready_o,
	input wire [`RC_NUM_INST-1:0] inst_pma_only_i,
	input wire [`RC_NUM_INST-1:0] inst_pipe_i,
	output reg [`RC_CTRL_W-1:0] reconfig_ctrl_o,
	output reg sel_valid_o,
	output reg [`RC_INST_W-1:0] sel_inst_o,
	output reg [`RC_CHAN_W-1:0] sel_chan_o,
	output reg sel_is_pll_o,
	output reg sel_pll_index_o,
	output reg sel_pcs_present_o,
	output reg [`RC_NUM_INST-1:0] ocal_fixed_clk_sel_o,
	output reg busy_o,
	output reg done_o,
	output reg addr_err_o
);

// ------------------------------------------------------------
// states
// ------------------------------------------------------------
localparam [4:0] ST_IDLE = 5'h01;
localparam [4:0] ST_DECODE = 5'h02;
localparam [4:0] ST_LOAD = 5'h04;
localparam [4:0] ST_SHIFT = 5'h08;
localparam [4:0] ST_DONE = 5'h10;

reg [4:0] state;
reg [4:0] next_state;
reg [`RC_MODE_W-1:0] req_mode;
reg [`RC_ADDR_W-1:0] req_addr;
reg req_pll_index;
reg [`RC_FRAME_W-1:0] shreg;
reg [`RC_CNT_W-1:0] bit_cnt;
reg last_word;
reg next_hit;
reg [`RC_INST_W-1:0] next_inst;
reg [`RC_CHAN_W-1:0] next_chan;
reg next_is_pll;
reg next_pcs;
integer k;

wire image_mode;
wire pll_sel_mode;
wire addr_in_total;

// ------------------------------------------------------------
// instance start addresses and per-instance decode
// ------------------------------------------------------------
// each span is a multiple of four, so every later instance already
// begins on the next multiple of four
wire [`RC_ADDR_W-1:0] start_addr [0:`RC_NUM_INST];
wire [`RC_NUM_INST-1:0] inst_hit;
wire [`RC_NUM_INST-1:0] inst_pll_hit;
wire [`RC_CHAN_W-1:0] inst_chan [0:`RC_NUM_INST-1];

assign start_addr[0] = `RC_ADDR_ZERO; // RQ2

genvar g;
generate
	for (g = 0; g < `RC_NUM_INST; g = g + 1) begin : g_inst
		wire [`RC_ADDR_W-1:0] off;
		wire [`RC_ADDR_W-1:0] pma_idx;
		wire in_inst;
		wire pma_ch_hit;
		wire pma_pll_hit;
		wire reg_ch_hit;

		assign start_addr[g+1] = start_addr[g] + (inst_pma_only_i[g] ? `RC_PMA_SPAN : `RC_REG_SPAN); // RQ3
		assign off = req_addr - start_addr[g];
		assign pma_idx = off >> `RC_PMA_SHIFT;
		assign in_inst = (req_addr >= start_addr[g]) && (req_addr < start_addr[g+1]);
		// PMA-only channels sit on every fourth address, the PLL after them
		assign pma_ch_hit = ((off & `RC_PMA_ALIGN_MASK) == `RC_ADDR_ZERO) && (off < `RC_PMA_PLL_OFF); // RQ14
		assign pma_pll_hit = (off == `RC_PMA_PLL_OFF) && pll_sel_mode; // RQ8
		assign reg_ch_hit = off < `RC_REG_SPAN; // RQ2
		assign inst_hit[g] = in_inst && (inst_pma_only_i[g] ? (pma_ch_hit || pma_pll_hit) : reg_ch_hit); // RQ1
		assign inst_pll_hit[g] = inst_pma_only_i[g] && pma_pll_hit;
		assign inst_chan[g] = inst_pma_only_i[g] ? pma_idx[`RC_CHAN_W-1:0] : off[`RC_CHAN_W-1:0];
	end
endgenerate

assign addr_in_total = req_addr < start_addr[`RC_NUM_INST]; // RQ16

// ------------------------------------------------------------
// mode classes
// ------------------------------------------------------------
assign image_mode = (req_mode == `RC_MODE_PLL_RECONF) ||
	(req_mode == `RC_MODE_CH_AND_PLL) ||
	(req_mode == `RC_MODE_CH_PLL_SEL); // RQ6
assign pll_sel_mode = req_mode == `RC_MODE_CH_PLL_SEL;

assign req_ready_o = state == ST_IDLE;
assign image_ready_o = state == ST_LOAD;

// ------------------------------------------------------------
// address to channel lookup
// ------------------------------------------------------------
always @* begin
	next_hit = 1'b0;
	next_inst = {`RC_INST_W{1'b0}};
	next_chan = {`RC_CHAN_W{1'b0}};
	next_is_pll = 1'b0;
	next_pcs = 1'b0;
	// regions never overlap; the lowest matching instance is taken
	for (k = `RC_NUM_INST - 1; k >= 0; k = k - 1) begin
		if (inst_hit[k] && addr_in_total) begin // RQ16
			next_hit = 1'b1;
			next_inst = k[`RC_INST_W-1:0];
			next_chan = inst_chan[k];
			next_is_pll = inst_pll_hit[k];
			next_pcs = ~inst_pma_only_i[k]; // RQ13
		end
	end
end

// ------------------------------------------------------------
// sequencer
// ------------------------------------------------------------
always @* begin
	next_state = state;
	case (state)
		ST_IDLE: begin
			if (req_valid_i) begin
				next_state = ST_DECODE;
			end
		end
		ST_DECODE: begin
			// outside the image group a request only moves the selection
			if (next_hit && image_mode) begin // RQ5
				next_state = ST_LOAD;
			end else begin
				next_state = ST_DONE;
			end
		end
		ST_LOAD: begin
			if (image_valid_i) begin
				next_state = ST_SHIFT;
			end
		end
		ST_SHIFT: begin
			if (bit_cnt == `RC_FRAME_LAST) begin
				next_state = last_word ? ST_DONE : ST_LOAD;
			end
		end
		ST_DONE: begin
			next_state = ST_IDLE;
		end
		default: begin
			next_state = ST_IDLE;
		end
	endcase
end

// all state lives on the one reconfiguration clock
always @(posedge clk_sys_i) begin // RQ17
	if (!rst_n_i) begin
		state <= ST_IDLE;
		req_mode <= `RC_MODE_PMA_CTRL;
		req_addr <= `RC_ADDR_ZERO;
		req_pll_index <= 1'b0;
		shreg <= {`RC_FRAME_W{1'b0}};
		bit_cnt <= `RC_CNT_ZERO;
		last_word <= 1'b0;
	end else begin
		state <= next_state;
		if (state == ST_IDLE && req_valid_i) begin
			req_mode <= req_mode_i;
			req_addr <= req_addr_i;
			req_pll_index <= req_pll_index_i; // RQ7
		end
		if (state == ST_LOAD && image_valid_i) begin
			// frame is address, PLL index, then the 16-bit word, MSB first
			shreg <= {req_addr, req_pll_index, image_word_i}; // RQ4
			last_word <= image_last_i;
			bit_cnt <= `RC_CNT_ZERO;
		end else if (state == ST_SHIFT) begin
			shreg <= {shreg[`RC_FRAME_W-2:0], 1'b0};
			bit_cnt <= bit_cnt + `RC_CNT_ONE;
		end
	end
end

// ------------------------------------------------------------
// transceiver control bus and selection outputs
// ------------------------------------------------------------
// bus bits: [2] frame, [1] serial data, [0] bit strobe; one bus drives
// every instance, each instance matches its own address in the frame
always @(posedge clk_sys_i) begin
	if (!rst_n_i) begin
		reconfig_ctrl_o <= {`RC_CTRL_W{1'b0}};
		sel_valid_o <= 1'b0;
		sel_inst_o <= {`RC_INST_W{1'b0}};
		sel_chan_o <= {`RC_CHAN_W{1'b0}};
		sel_is_pll_o <= 1'b0;
		sel_pll_index_o <= 1'b0;
		sel_pcs_present_o <= 1'b0;
		ocal_fixed_clk_sel_o <= {`RC_NUM_INST{1'b0}};
		busy_o <= 1'b0;
		done_o <= 1'b0;
		addr_err_o <= 1'b0;
	end else begin
		if (state == ST_SHIFT) begin
			reconfig_ctrl_o <= {1'b1, shreg[`RC_FRAME_W-1], 1'b1}; // RQ15
		end else begin
			reconfig_ctrl_o <= {`RC_CTRL_W{1'b0}};
		end
		// a rejected address leaves the previous selection untouched
		if (state == ST_DECODE && next_hit) begin // RQ16
			sel_valid_o <= 1'b1;
			sel_inst_o <= next_inst; // RQ9
			sel_chan_o <= next_chan; // RQ1
			sel_is_pll_o <= next_is_pll; // RQ8
			sel_pll_index_o <= req_pll_index; // RQ7
			sel_pcs_present_o <= next_pcs; // RQ13
		end
		// PIPE instances run offset cancellation from the fixed clock
		ocal_fixed_clk_sel_o <= inst_pipe_i; // RQ10
		busy_o <= next_state != ST_IDLE;
		done_o <= state == ST_DONE;
		addr_err_o <= state == ST_DECODE && !next_hit;
	end
end

endmodule // xcvr_reconfig_channel_addressing

// ---- verif/xcvr_reconfig_checks_assertions.sv ----
// port assertions for the channel addressing front end
`timescale 1ns/1ns
module xcvr_reconfig_checks (
	input wire clk_sys_i, rst_n_i, req_valid_i, req_ready_o, image_valid_i, image_ready_o,
	input wire sel_valid_o, sel_is_pll_o, sel_pcs_present_o, busy_o, done_o, addr_err_o,
	input wire [2:0] req_mode_i, reconfig_ctrl_o,
	input wire [0:0] sel_inst_o,
	input wire [1:0] inst_pma_only_i, inst_pipe_i, ocal_fixed_clk_sel_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	// ----------------------------------------
	// request steps
	// ----------------------------------------
	sequence s_take; req_valid_i && req_ready_o; endsequence
	sequence s_flat; s_take ##0 (req_mode_i == 3'h0 || req_mode_i > 3'h3); endsequence
	sequence s_word; image_valid_i && image_ready_o; endsequence
	property p_flat_done; s_flat |-> ##3 done_o; endproperty
	property p_no_img; s_flat |=> !image_ready_o [*3]; endproperty
	property p_busy; s_take |=> busy_o && !req_ready_o; endproperty
	property p_err; addr_err_o |-> $stable(sel_inst_o) && $stable(sel_valid_o) ##1 (done_o && !addr_err_o); endproperty
	property p_done; done_o |-> req_ready_o ##1 !done_o; endproperty
	property p_word; s_word |-> ##2 (reconfig_ctrl_o[2] && reconfig_ctrl_o[0]) [*8]; endproperty
	property p_strobe; reconfig_ctrl_o[0] |-> reconfig_ctrl_o[2] && busy_o; endproperty
	property p_pcs; sel_valid_o && !sel_is_pll_o |-> sel_pcs_present_o == !inst_pma_only_i[sel_inst_o]; endproperty
	property p_pll; sel_is_pll_o |-> !sel_pcs_present_o && inst_pma_only_i[sel_inst_o]; endproperty
	property p_ocal; 1 |=> ocal_fixed_clk_sel_o == $past(inst_pipe_i); endproperty
	property p_reset; $rose(rst_n_i) |-> !busy_o && !sel_valid_o && !done_o && req_ready_o; endproperty
	a_flat_done: assert property (p_flat_done) else $error("flat request did not finish in time");
	a_no_img: assert property (p_no_img) else $error("image word offered in a flat mode");
	a_busy: assert property (p_busy) else $error("busy missing after request");
	a_err: assert property (p_err) else $error("rejected address changed selection");
	a_done: assert property (p_done) else $error("done pulse wrong");
	a_word: assert property (p_word) else $error("image frame too short");
	a_strobe: assert property (p_strobe) else $error("strobe outside frame");
	a_pcs: assert property (p_pcs) else $error("pcs flag wrong");
	a_pll: assert property (p_pll) else $error("pll selected outside pma instance");
	a_ocal: assert property (p_ocal) else $error("offset clock select wrong");
	a_reset: assert property (p_reset) else $error("not idle after reset");
endmodule // xcvr_reconfig_checks
bind xcvr_reconfig_channel_addressing xcvr_reconfig_checks chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
	.req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .image_valid_i(image_valid_i),
	.image_ready_o(image_ready_o), .sel_valid_o(sel_valid_o), .sel_is_pll_o(sel_is_pll_o),
	.sel_pcs_present_o(sel_pcs_present_o), .busy_o(busy_o), .done_o(done_o), .addr_err_o(addr_err_o),
	.req_mode_i(req_mode_i), .reconfig_ctrl_o(reconfig_ctrl_o), .sel_inst_o(sel_inst_o),
	.inst_pma_only_i(inst_pma_only_i), .inst_pipe_i(inst_pipe_i), .ocal_fixed_clk_sel_o(ocal_fixed_clk_sel_o));

// ---- verif/xcvr_far_end.sv ----
// far side model: collects serial frames from the control bus
`timescale 1ns/1ns
module xcvr_far_end (
	input wire clk_sys_i,
	input wire [2:0] ctrl_i,
	output reg [22:0] frame_o,
	output reg [7:0] count_o
);
	reg [22:0] sh = 0;
	reg [4:0] nb = 0;
	initial begin
		frame_o = 0;
		count_o = 0;
	end
	// counting bits, not frame edges, so back-to-back words stay apart
	always @(posedge clk_sys_i) begin
		if (!ctrl_i[2]) nb <= 0;
		else if (ctrl_i[0]) begin
			sh <= {sh[21:0], ctrl_i[1]};
			nb <= (nb == 22) ? 5'h00 : nb + 5'h01;
			if (nb == 22) begin
				frame_o <= {sh[21:0], ctrl_i[1]};
				count_o <= count_o + 8'h01;
			end
		end
	end
endmodule // xcvr_far_end

// ---- verif/tb_top.sv ----
// self-checking bench for the channel addressing front end
`timescale 1ns/1ns
`include "xcvr_reconfig_map.vh"
module tb_top;
	reg clk_sys_i = 0, rst_n_i = 0, req_valid_i = 0, req_pll_index_i = 0, image_valid_i = 0, image_last_i = 0;
	reg [2:0] req_mode_i = 0;
	reg [5:0] req_addr_i = 0;
	reg [15:0] image_word_i = 0, w;
	reg [1:0] inst_pma_only_i = 0, inst_pipe_i = 0;
	wire req_ready_o, image_ready_o, sel_valid_o, sel_is_pll_o, sel_pll_index_o, sel_pcs_present_o;
	wire busy_o, done_o, addr_err_o;
	wire [2:0] reconfig_ctrl_o;
	wire [0:0] sel_inst_o;
	wire [1:0] sel_chan_o, ocal_fixed_clk_sel_o;
	wire [22:0] last_frame;
	wire [7:0] frames;
	integer seed = 54, mismatches = 0, checks_done = 0, i, j, k, n;
	reg [6:0] e_sel;
	reg [7:0] f0, df;
	reg err;
	xcvr_reconfig_channel_addressing dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
		.req_mode_i(req_mode_i), .req_addr_i(req_addr_i), .req_pll_index_i(req_pll_index_i),
		.req_ready_o(req_ready_o), .image_valid_i(image_valid_i), .image_word_i(image_word_i),
		.image_last_i(image_last_i), .image_ready_o(image_ready_o), .inst_pma_only_i(inst_pma_only_i),
		.inst_pipe_i(inst_pipe_i), .reconfig_ctrl_o(reconfig_ctrl_o), .sel_valid_o(sel_valid_o),
		.sel_inst_o(sel_inst_o), .sel_chan_o(sel_chan_o), .sel_is_pll_o(sel_is_pll_o),
		.sel_pll_index_o(sel_pll_index_o), .sel_pcs_present_o(sel_pcs_present_o),
		.ocal_fixed_clk_sel_o(ocal_fixed_clk_sel_o), .busy_o(busy_o), .done_o(done_o), .addr_err_o(addr_err_o));
	// the far side runs on the same reconfiguration clock as the controller
	xcvr_far_end far (.clk_sys_i(clk_sys_i), .ctrl_i(reconfig_ctrl_o), .frame_o(last_frame), .count_o(frames));
	// free running from time zero, never gated, as offset cancellation needs it at power-up
	initial forever #2 clk_sys_i = ~clk_sys_i;
	task tally_and_finish;
		begin
			$display("checks %0d mismatches %0d", checks_done, mismatches);
			if (mismatches == 0 && checks_done > 0) $display("Finished cleanly");
			else $display("Finished with errors");
			$finish;
		end
	endtask
	task check(input [63:0] nm, input [22:0] seen, input [22:0] exp);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp) begin
				mismatches = mismatches + 1;
				$display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	// {valid, inst, chan, is_pll, pll index, pcs}; all zero means a miss
	function [6:0] decode(input [2:0] m, input [5:0] a, input p);
		reg [5:0] s0, o;
		reg i1, pm;
		begin
			s0 = inst_pma_only_i[0] ? 6'h14 : 6'h04;
			i1 = a >= s0;
			o = a - (i1 ? s0 : 6'h00);
			pm = inst_pma_only_i[i1];
			decode = 0;
			if (!pm && o < 4) decode = {1'b1, i1, o[1:0], 1'b0, p, 1'b1};
			else if (pm && o < 16 && o[1:0] == 0) decode = {1'b1, i1, o[3:2], 1'b0, p, 1'b0};
			else if (pm && o == 16 && m == 3) decode = {1'b1, i1, 2'h0, 1'b1, p, 1'b0};
		end
	endfunction
	task rst(input [1:0] pm);
		begin
			@(negedge clk_sys_i);
			rst_n_i = 0;
			inst_pma_only_i = pm;
			inst_pipe_i = $random(seed);
			repeat (2) @(negedge clk_sys_i);
			rst_n_i = 1;
			e_sel = 0;
			@(negedge clk_sys_i);
			check("idle", {busy_o, sel_valid_o, req_ready_o, image_ready_o}, 4'h2);
			check("ocal", ocal_fixed_clk_sel_o, inst_pipe_i);
		end
	endtask
	task run(input [2:0] m, input [5:0] a, input p, input [1:0] nw);
		reg [6:0] d, s;
		reg img;
		begin
			d = decode(m, a, p);
			img = m > 0 && m < 4;
			f0 = frames;
			err = 0;
			@(negedge clk_sys_i);
			req_valid_i = 1;
			req_mode_i = m;
			req_addr_i = a;
			req_pll_index_i = p;
			image_valid_i = !img;
			for (k = 0; k < 50 && !req_ready_o; k = k + 1) @(negedge clk_sys_i);
			check("rdy", req_ready_o, 1'b1);
			@(negedge clk_sys_i);
			req_valid_i = 0;
			if (d[6] && img) begin
				for (n = 1; n <= nw; n = n + 1) begin
					w = $random(seed);
					image_valid_i = 1;
					image_word_i = w;
					image_last_i = n == nw;
					for (k = 0; k < 80 && !image_ready_o; k = k + 1) @(negedge clk_sys_i);
					check("iready", image_ready_o, 1'b1);
					@(negedge clk_sys_i);
				end
				image_valid_i = 0;
			end
			for (k = 0; k < 200 && done_o !== 1; k = k + 1) begin
				@(negedge clk_sys_i);
				if (addr_err_o === 1) err = 1;
			end
			check("done", done_o, 1'b1);
			image_valid_i = 0;
			@(negedge clk_sys_i);
			// the frame counter wraps, so the difference is taken at its own width
			df = frames - f0;
			check("err", err, !d[6]);
			check("frames", df, (d[6] && img) ? nw : 0);
			if (d[6] && img) check("frame", last_frame, {a, p, w});
			if (d[6]) e_sel = d;
			s = {sel_valid_o, sel_inst_o, sel_chan_o, sel_is_pll_o, sel_pll_index_o, sel_pcs_present_o};
			if (e_sel[2]) s[4:3] = e_sel[4:3];
			check("sel", s, e_sel);
		end
	endtask
	initial begin
		for (i = 0; i < 4; i = i + 1) begin
			rst(i);
			run(3'h3, 6'h10, 1, 2'h1);
			run(3'h1, 6'h10, 0, 2'h1);
			run(3'h3, 6'h24, 1, 2'h2);
			for (j = 0; j < 24; j = j + 1) run((i + j) % 6, (j >> 1) * 4 - (j & 1), j, 2'h2);
			for (j = 0; j < 30; j = j + 1) run($unsigned($random(seed)) % 6, $random(seed), $random(seed),
				$unsigned($random(seed)) % 3 + 1);
		end
		tally_and_finish;
	end
	initial begin
		// about 230 requests of at most ~90 cycles each; 50k cycles leaves ample margin
		#200000;
		mismatches = mismatches + 1;
		tally_and_finish;
	end
endmodule // tb_top
